// *** rtl/banked_memory_address_map.v ***
// address map for program fetch and banked data memory with core registers
`timescale 1ns/1ps
`include "memory_map_defines.vh"
module banked_memory_address_map #(
    parameter PROG_WORDS_LOG2 = 13
) (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // program side
    input  wire        i_fetch_adv,
    input  wire        i_int_take,
    input  wire        i_pc_load,
    input  wire [12:0] i_pc_load_addr,
    output wire [12:0] o_prog_addr,
    output wire [12:0] o_pc,
    // data side
    input  wire        i_data_rd,
    input  wire        i_data_wr,
    input  wire [6:0]  i_data_ofs,
    input  wire [7:0]  i_data_wdata,
    output reg  [7:0]  o_data_rdata,
    output wire [1:0]  o_bank,
    output wire [7:0]  o_status
);

////////////////////////////////////////////////////////////////////////////////
// program counter
reg  [12:0] pc_q;
reg  [12:0] pc_d;
reg  [7:0]  status_q;
reg  [7:0]  file_ptr_q;
reg  [7:0]  pc_high_latch_q;

// a log2 of 13 or more keeps every pc bit; anything less wraps the fetch
localparam [12:0] PROG_MASK = (PROG_WORDS_LOG2 >= 13) ? 13'h1fff :
                              ((13'h0001 << PROG_WORDS_LOG2) - 13'h0001);

assign o_pc        = pc_q;
assign o_prog_addr = pc_q & PROG_MASK;

// a data write to the low pc byte jumps, the high latch giving the upper bits
wire pc_low_wr;

// priority: interrupt, then load, then data write, then plain advance
always @* begin
    pc_d = pc_q;
    if (i_int_take) begin
        pc_d = `INT_VECTOR;
    end else if (i_pc_load) begin
        pc_d = i_pc_load_addr;
    end else if (pc_low_wr) begin
        pc_d = {pc_high_latch_q[4:0], i_data_wdata};
    end else if (i_fetch_adv) begin
        pc_d = pc_q + 13'h0001;
    end
end

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        pc_q <= `RESET_VECTOR;
    end else begin
        pc_q <= pc_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// data address decode
// bank bits from status; indirect uses the pointer's bit 7 with status bit 6
assign o_bank   = {status_q[`STATUS_BANK_HI], status_q[`STATUS_BANK_LO]};
assign o_status = status_q;

// region codes for one decoded data location
localparam [2:0] REG_NONE     = 3'b000;
localparam [2:0] REG_PC_LOW   = 3'b001;
localparam [2:0] REG_STATUS   = 3'b010;
localparam [2:0] REG_FILE_PTR = 3'b011;
localparam [2:0] REG_PC_LATCH = 3'b100;
localparam [2:0] REG_BANKED   = 3'b101;
localparam [2:0] REG_SHARED   = 3'b110;

// sort a bank offset into the region it reaches; core registers ignore the bank
function [2:0] region_of;
    input [6:0] ofs;
    begin
        if (ofs == `OFS_PC_LOW) begin
            region_of = REG_PC_LOW;
        end else if (ofs == `OFS_STATUS) begin
            region_of = REG_STATUS;
        end else if (ofs == `OFS_FILE_PTR) begin
            region_of = REG_FILE_PTR;
        end else if (ofs == `OFS_PC_HIGH_LATCH) begin
            region_of = REG_PC_LATCH;
        end else if (ofs >= `OFS_SHARED_FIRST) begin
            region_of = REG_SHARED;
        end else if (ofs >= `OFS_GPR_FIRST) begin
            region_of = REG_BANKED;
        end else begin
            region_of = REG_NONE;
        end
    end
endfunction

// row of a banked byte: 80 bytes a bank, so bank times 64 plus bank times 16
function [8:0] bank_index;
    input [1:0] bank;
    input [6:0] ofs;
    begin
        bank_index = {1'b0, bank, 6'h00} + {3'h0, bank, 4'h0} + {2'h0, ofs} -
                     {2'h0, `OFS_GPR_FIRST};
    end
endfunction

wire       indirect = (i_data_ofs == `OFS_INDIRECT);
wire [1:0] eff_bank = indirect ? {status_q[`STATUS_BANK_HI], file_ptr_q[7]} : o_bank;
wire [6:0] eff_ofs  = indirect ? file_ptr_q[6:0] : i_data_ofs;

// a pointer aimed back at offset 00h touches nothing and reads zero
wire null_ind = indirect && (file_ptr_q[6:0] == `OFS_INDIRECT);

wire [2:0] region     = null_ind ? REG_NONE : region_of(eff_ofs);
wire [8:0] banked_idx = bank_index(eff_bank, eff_ofs);
wire [3:0] shared_idx = eff_ofs[3:0];

// core registers, one copy each, seen in all four banks
wire status_wr   = i_data_wr && (region == REG_STATUS);
wire file_ptr_wr = i_data_wr && (region == REG_FILE_PTR);
wire latch_wr    = i_data_wr && (region == REG_PC_LATCH);
wire banked_wr   = i_data_wr && (region == REG_BANKED);
wire shared_wr   = i_data_wr && (region == REG_SHARED);

assign pc_low_wr = i_data_wr && (region == REG_PC_LOW);

// 4 banks of 80 bytes plus 16 shared bytes
reg  [7:0] banked_ram [0:319];
reg  [7:0] shared_ram [0:15];

////////////////////////////////////////////////////////////////////////////////
// core register writes
always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        status_q <= `STATUS_RESET;
    end else if (status_wr) begin
        status_q <= i_data_wdata;
    end
end

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        file_ptr_q <= `FILE_PTR_RESET;
    end else if (file_ptr_wr) begin
        file_ptr_q <= i_data_wdata;
    end
end

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        pc_high_latch_q <= `PC_HIGH_RESET;
    end else if (latch_wr) begin
        pc_high_latch_q <= i_data_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// ram writes
// ram has no reset; contents are undefined until written
always @(posedge i_clk) begin
    if (banked_wr) begin
        banked_ram[banked_idx] <= i_data_wdata;
    end
    if (shared_wr) begin
        shared_ram[shared_idx] <= i_data_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////////
// read data, registered; runs alongside fetch every cycle
// the value holds between reads so the core may sample it late
reg [7:0] rdata_d;

always @* begin
    rdata_d = o_data_rdata;
    if (i_data_rd) begin
        case (region)
            REG_PC_LOW: begin
                rdata_d = pc_q[7:0];
            end
            REG_STATUS: begin
                rdata_d = status_q;
            end
            REG_FILE_PTR: begin
                rdata_d = file_ptr_q;
            end
            REG_PC_LATCH: begin
                rdata_d = {3'b000, pc_high_latch_q[4:0]};
            end
            REG_SHARED: begin
                rdata_d = shared_ram[shared_idx];
            end
            REG_BANKED: begin
                rdata_d = banked_ram[banked_idx];
            end
            default: begin
                rdata_d = 8'h00;
            end
        endcase
    end
end

always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
        o_data_rdata <= 8'h00;
    end else begin
        o_data_rdata <= rdata_d;
    end
end

endmodule

// *** rtl/memory_map_defines.vh ***
// constants for the banked program and data memory address map
`ifndef MEMORY_MAP_DEFINES_VH
`define MEMORY_MAP_DEFINES_VH
`define RESET_VECTOR      13'h0000
`define INT_VECTOR        13'h0004
`define OFS_INDIRECT      7'h00
`define OFS_PC_LOW        7'h02
`define OFS_STATUS        7'h03
`define OFS_FILE_PTR      7'h04
`define OFS_PC_HIGH_LATCH 7'h0a
`define OFS_GPR_FIRST     7'h20
`define OFS_SHARED_FIRST  7'h70
`define STATUS_BANK_HI    6
`define STATUS_BANK_LO    5
`define STATUS_RESET      8'h18
`define FILE_PTR_RESET    8'h00
`define PC_HIGH_RESET     8'h00
`endif

// *** testbench/banked_map_assertions.sv ***
// assertions on the memory map ports
`timescale 1ns/1ps
module banked_map_checker #(parameter PROG_WORDS_LOG2 = 13) (
    input wire i_clk, i_rst, i_fetch_adv, i_int_take, i_pc_load, i_data_rd, i_data_wr,
    input wire [12:0] i_pc_load_addr, o_prog_addr, o_pc,
    input wire [6:0] i_data_ofs,
    input wire [7:0] i_data_wdata, o_data_rdata, o_status,
    input wire [1:0] o_bank);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_rd_unimpl;
        i_data_rd && i_data_ofs inside {[7'h05:7'h09], [7'h0b:7'h1f]};
    endsequence
    chk_reset_vector: assert property (disable iff (1'b0) i_rst |=> o_pc == 13'h0000)
        else $error("pc off reset");
    chk_int_vector: assert property (i_int_take |=> o_pc == 13'h0004)
        else $error("int vector");
    chk_pc_load: assert property (i_pc_load && !i_int_take |=> o_pc == $past(i_pc_load_addr))
        else $error("pc load");
    chk_fetch_inc: assert property (i_fetch_adv && !i_int_take && !i_pc_load && !i_data_wr
        |=> o_pc == $past(o_pc) + 13'h0001) else $error("pc step");
    chk_prog_wrap: assert property (o_prog_addr == (o_pc & ((13'h0001 << PROG_WORDS_LOG2) - 1)))
        else $error("wrap");
    chk_bank_sel: assert property (o_bank == o_status[6:5]) else $error("bank");
    chk_status_wr: assert property (i_data_wr && i_data_ofs == 7'h03
        |=> o_bank == $past(i_data_wdata[6:5])) else $error("status");
    chk_unimpl_zero: assert property (s_rd_unimpl |=> o_data_rdata == 8'h00) else $error("unimpl");
endmodule
bind banked_memory_address_map banked_map_checker #(.PROG_WORDS_LOG2(PROG_WORDS_LOG2)) u_chk (.*);

// *** testbench/core_fetch_model.sv ***
// core side model: one fetch advance per cycle while running
`timescale 1ns/1ps
module core_fetch_model (
    input  wire  i_clk,
    input  wire  i_run,
    output logic o_adv);
    initial o_adv = 1'b0;
    always @(posedge i_clk) o_adv <= i_run;
endmodule

// *** testbench/tb_top.sv ***
// testbench for the banked memory address map
`timescale 1ns/1ps
module tb_top;
    logic i_clk = 0, i_rst = 1, i_int_take = 0, i_pc_load = 0, i_data_rd = 0, i_data_wr = 0, run = 0;
    logic [12:0] i_pc_load_addr = 0;
    logic [6:0] i_data_ofs = 0, a;
    logic [7:0] i_data_wdata = 0, d;
    wire i_fetch_adv;
    wire [12:0] o_prog_addr, o_pc;
    wire [7:0] o_data_rdata, o_status;
    wire [1:0] o_bank;
    int n_mismatch = 0, checks_done = 0, cyc = 0;
    core_fetch_model core (.i_clk(i_clk), .i_run(run), .o_adv(i_fetch_adv));
    banked_memory_address_map #(.PROG_WORDS_LOG2(12)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_fetch_adv(i_fetch_adv), .i_int_take(i_int_take),
        .i_pc_load(i_pc_load), .i_pc_load_addr(i_pc_load_addr), .o_prog_addr(o_prog_addr),
        .o_pc(o_pc), .i_data_rd(i_data_rd), .i_data_wr(i_data_wr), .i_data_ofs(i_data_ofs),
        .i_data_wdata(i_data_wdata), .o_data_rdata(o_data_rdata), .o_bank(o_bank),
        .o_status(o_status));
    function automatic logic [7:0] status_for(input int b);
        return {1'b0, 2'(b), 5'h18};
    endfunction
    initial forever #25 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin n_mismatch++; complete_run(); end
    end
    task automatic cmp(input logic [12:0] got, exp);
        checks_done++;
        if (got !== exp) begin n_mismatch++; $display("FAIL %0t got %h exp %h", $time, got, exp); end
    endtask
    task automatic wr(input logic [6:0] o, input logic [7:0] v);
        @(posedge i_clk) {i_data_wr, i_data_ofs, i_data_wdata} <= {1'b1, o, v};
        @(posedge i_clk) i_data_wr <= 0;
        #1;
    endtask
    task automatic rd(input logic [6:0] o, input logic [7:0] e);
        @(posedge i_clk) {i_data_rd, i_data_ofs} <= {1'b1, o};
        @(posedge i_clk) i_data_rd <= 0;
        #1 cmp(o_data_rdata, e);
    endtask
    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        d = $urandom(20908);
        d = $urandom;
        a = 7'h20 + 7'($urandom % 80);
        repeat (5) @(posedge i_clk);
        i_rst <= 0;
        #1 cmp(o_pc, 0);
        // distinct data per bank proves the banks do not alias
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, status_for(b));
            cmp(o_bank, 13'(b));
            cmp(o_status, 13'(status_for(b)));
            wr(a, d + 8'(b));
            wr(7'h05, d);
        end
        wr(7'h70, ~d);
        wr(7'h04, {1'b0, a});
        for (int b = 0; b < 4; b++) begin
            wr(7'h03, status_for(b));
            rd(a, d + 8'(b));
            rd(7'h70, ~d);
            rd(7'h04, {1'b0, a});
            rd(7'h05, 8'h00);
        end
        wr(7'h03, 8'h18);
        rd(7'h00, d);
        // bank 0 at 40h and bank 1 at 20h must be separate bytes
        wr(7'h40, 8'h5a);
        wr(7'h03, status_for(1));
        wr(7'h20, 8'ha5);
        wr(7'h03, status_for(0));
        rd(7'h40, 8'h5a);
        wr(7'h0a, 8'h01);
        wr(7'h02, 8'h23);
        cmp(o_pc, 13'h0123);
        rd(7'h02, 8'h23);
        rd(7'h0a, 8'h01);
        $display("data tests done");
        @(posedge i_clk) {i_pc_load, i_pc_load_addr} <= {1'b1, 13'h1fff};
        @(posedge i_clk) {i_pc_load, run} <= 2'b01;
        #1 cmp(o_prog_addr, 13'h0fff);
        @(posedge i_clk) run <= 0;
        @(posedge i_clk) {i_int_take, i_pc_load} <= 2'b11;
        #1 cmp(o_pc, 13'h0000);
        @(posedge i_clk) {i_int_take, i_pc_load} <= 2'b00;
        #1 cmp(o_pc, 13'h0004);
        $display("program tests done");
        complete_run();
    end
endmodule
